// *** hdl/servo_speed_mode_control_defines.vh ***
// Constants of the servo speed and mode control block
//
// Notes on behaviour
// R01: Forward only CCW, reverse only CW, else lock
// R02: Select code picks command one to seven
// R03: Speed changes ramp by accel/decel times
// R04: Speed-reached output when speed nears command
// R05: Config value 0001 enables change mode
// R06: Change input low position, high speed control
// R07: Mode change happens only at zero speed
// R08: Position to speed change clears droop pulses
// R09: Toggle above zero speed blocks the change
// R10: Speed phase: one select picks command 1/2
// R11: Change mode speed changes also ramp
// R12: Any alarm shuts the drive base off
// R13: Alarm cleared by power cycle, button, reset edge
// R14: No clear while alarm cause remains
// R15: Undervoltage on long power loss or low bus
// R16: Alarm in position control loses home
// R17: Distinct codes for each alarm source
// R18: Start functions mapped onto assignable pins
// R19: Torque select takes smaller of two limits
// R20: Contact inputs synchronised, zero speed computed each cycle
`ifndef SERVO_SPEED_MODE_CONTROL_DEFINES_VH
`define SERVO_SPEED_MODE_CONTROL_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_PIN_MAP     8'h04
`define REG_SPEED_FIRST 8'h08
`define REG_SPEED_LAST  8'h20
`define REG_ACCEL_TIME  8'h24
`define REG_DECEL_TIME  8'h28
`define REG_TORQUE_LIM1 8'h2C
`define REG_TORQUE_LIM2 8'h30
`define REG_ZERO_LEVEL  8'h34
`define REG_SA_WINDOW   8'h38
`define REG_STATUS      8'h3C

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define MODE_POSITION   4'h0
`define MODE_CHANGE     4'h1
`define MODE_SPEED      4'h2
`define DIR_STOP        2'h0
`define DIR_CCW         2'h1
`define DIR_CW          2'h2
`define RST_FWD_PIN     3'h0
`define RST_REV_PIN     3'h1
`define RST_ZERO_LEVEL  16'h0032
`define RST_SA_WINDOW   16'h0032
`define RST_TORQUE_LIM  16'h03E8
`define PIN_COUNT       3'h6

// ----------------------------------------------------------------
// Alarm codes
// ----------------------------------------------------------------
`define ALM_NONE        8'h00
`define ALM_UNDERVOLT   8'h10
`define ALM_REGEN       8'h30
`define ALM_OVERCURRENT 8'h32
`define ALM_OVERLOAD1   8'h50
`define ALM_OVERLOAD2   8'h51

// ----------------------------------------------------------------
// Timing and levels
// ----------------------------------------------------------------
`define CLK_MHZ         200
`define TICK_US         1
`define TICK_LAST       8'hC7
`define PWRFAIL_MS      60
`define PWRFAIL_TICK_COUNT 17'h0EA60
`define BUS_LOW_VOLTS   10'h0C8
`define HSIZE_WORD      3'h2

`endif

// *** hdl/servo_speed_mode_control.v ***
// Speed command, mode change and alarm logic of the servo amplifier
//
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`include "servo_speed_mode_control_defines.vh"

// ----------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------
module signal_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk_sys,
	input  wire             resetn,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			meta    <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end
		else
		begin
			meta    <= asyncIn;
			syncOut <= meta;
		end
	end
endmodule // signal_sync

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module servo_speed_mode_control #(
	parameter [16:0] PWRFAIL_TICKS = `PWRFAIL_TICK_COUNT
) (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        resetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Contact inputs
	input  wire [5:0]  assignPins,
	input  wire        speed_sel0_in,
	input  wire        speed_sel1_in,
	input  wire        speed_sel2_in,
	input  wire        ctrl_change_in,
	input  wire        alarm_reset_in,
	input  wire        servo_on_in,
	input  wire        torque_lim_sel_in,
	input  wire        panelSetIn,
	input  wire        homeDoneIn,
	// Measurements and faults from drive logic
	input  wire [15:0] actualSpeed,
	input  wire [9:0]  busVoltage,
	input  wire        ctrlPowerFail,
	input  wire        overCurrent,
	input  wire        overload1,
	input  wire        overload2,
	input  wire        regenError,
	// Drive outputs
	output reg         baseEnable,
	output reg  [15:0] speedCommand,
	output reg  [1:0]  rotDir,
	output reg         servoLock,
	output reg         droopClear,
	output reg  [15:0] torqueLimit,
	output reg         speedMode,
	output reg         speed_reached_out,
	output reg         zero_speed_flag,
	output reg         alarmActive,
	output reg  [7:0]  alarmCode,
	output reg         homeValid
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg  [3:0]  ctrlMode;
	reg         selEnable;
	reg  [2:0]  fwdPin;
	reg  [2:0]  revPin;
	reg  [15:0] speedSet [0:6];
	reg  [15:0] accelTime;
	reg  [15:0] decelTime;
	reg  [15:0] torqueLim1;
	reg  [15:0] torqueLim2;
	reg  [15:0] zeroLevel;
	reg  [15:0] saWindow;
	reg         wrPending;
	reg  [7:0]  wrAddr;
	reg  [31:0] next_hrdata;
	integer     i;

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	wire        sHome;
	wire        sSet;
	wire        sTorqueSel;
	wire        sServoOn;
	wire        sReset;
	wire        sChange;
	wire [2:0]  sSel;
	wire [5:0]  sPins;

	signal_sync #(.WIDTH(15)) u_sync ( // R20
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.asyncIn ({homeDoneIn, panelSetIn, torque_lim_sel_in, servo_on_in, alarm_reset_in,
			ctrl_change_in, speed_sel2_in, speed_sel1_in, speed_sel0_in, assignPins}),
		.syncOut ({sHome, sSet, sTorqueSel, sServoOn, sReset, sChange, sSel, sPins})
	);

	reg changeQ;
	reg resetQ;
	reg setQ;
	reg homeQ;
	reg pwrFailQ;

	// ------------------------------------------------------------
	// Combinational decode
	// ------------------------------------------------------------
	wire        fwdStart = (fwdPin < `PIN_COUNT) ? sPins[fwdPin] : 1'b0; // R18
	wire        revStart = (revPin < `PIN_COUNT) ? sPins[revPin] : 1'b0; // R18
	wire        changeMode = (ctrlMode == `MODE_CHANGE); // R05
	wire [15:0] absActual = actualSpeed[15] ? (~actualSpeed + 16'h0001) : actualSpeed;
	wire        zeroNow = (absActual <= zeroLevel); // R20
	wire        changeEdge = (sChange != changeQ);
	reg         changeBlocked;
	reg  [1:0]  next_dir;
	reg  [2:0]  selIndex;
	reg         next_speedMode;

	always @*
	begin
		if (fwdStart && !revStart) // R01
			next_dir = `DIR_CCW;
		else if (revStart && !fwdStart)
			next_dir = `DIR_CW;
		else
			next_dir = `DIR_STOP;
		if (changeMode && speedMode)
			selIndex = {2'h0, sSel[0]}; // R10
		else if (selEnable && (sSel > 3'h1))
			selIndex = sSel - 3'h1; // R02
		else
			selIndex = 3'h0;
		if (ctrlMode == `MODE_SPEED)
			next_speedMode = 1'b1;
		else if (!changeMode)
			next_speedMode = 1'b0;
		else if (zeroNow && !changeBlocked && !(changeEdge && !zeroNow)) // R07
			next_speedMode = sChange; // R06
		else
			next_speedMode = speedMode;
	end

	wire [15:0] selSpeed = speedSet[selIndex];
	wire [15:0] target = (!speedMode || !baseEnable || rotDir == `DIR_STOP) ? 16'h0000 :
		(rotDir == `DIR_CW) ? (~selSpeed + 16'h0001) : selSpeed;
	wire [16:0] speedDiff = (absActual > selSpeed) ? ({1'b0, absActual} - {1'b0, selSpeed}) :
		({1'b0, selSpeed} - {1'b0, absActual});
	wire        upward = ($signed(speedCommand) < $signed(target));
	wire        awayFromZero = upward ? !speedCommand[15] : (speedCommand[15] || speedCommand == 16'h0000);
	wire [15:0] rampRate = awayFromZero ? accelTime : decelTime; // R03 R11

	// ------------------------------------------------------------
	// Alarm causes
	// ------------------------------------------------------------
	reg  [16:0] pwrFailCnt;
	wire        busLow = sServoOn && (busVoltage <= `BUS_LOW_VOLTS);
	wire        pwrFailLong = pwrFailQ && !ctrlPowerFail && (pwrFailCnt >= PWRFAIL_TICKS);
	wire        anyCause = overCurrent | regenError | overload2 | overload1 | busLow | ctrlPowerFail;
	wire        anyEvent = overCurrent | regenError | overload2 | overload1 | busLow | pwrFailLong;
	wire        clearReq = (sReset && !resetQ) || (sSet && !setQ); // R13
	wire        next_baseEnable = sServoOn && !alarmActive && !anyEvent; // R12
	wire [7:0]  newCode = overCurrent ? `ALM_OVERCURRENT : regenError ? `ALM_REGEN : // R17
		overload2 ? `ALM_OVERLOAD2 : overload1 ? `ALM_OVERLOAD1 : `ALM_UNDERVOLT; // R15

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	wire       addrPhase = hsel && htrans[1] && hready;
	wire [7:0] rdAddr = {haddr[7:2], 2'b00};
	wire [7:0] spOffset = rdAddr - `REG_SPEED_FIRST;

	always @*
	begin
		next_hrdata = 32'h00000000;
		if (rdAddr >= `REG_SPEED_FIRST && rdAddr <= `REG_SPEED_LAST && haddr[31:8] == 24'h000000)
			next_hrdata = {16'h0000, speedSet[spOffset[4:2]]};
		else if (haddr[31:8] == 24'h000000)
		begin
			case (rdAddr)
				`REG_CTRL:        next_hrdata = {27'h0000000, selEnable, ctrlMode};
				`REG_PIN_MAP:     next_hrdata = {25'h0000000, revPin, 1'b0, fwdPin};
				`REG_ACCEL_TIME:  next_hrdata = {16'h0000, accelTime};
				`REG_DECEL_TIME:  next_hrdata = {16'h0000, decelTime};
				`REG_TORQUE_LIM1: next_hrdata = {16'h0000, torqueLim1};
				`REG_TORQUE_LIM2: next_hrdata = {16'h0000, torqueLim2};
				`REG_ZERO_LEVEL:  next_hrdata = {16'h0000, zeroLevel};
				`REG_SA_WINDOW:   next_hrdata = {16'h0000, saWindow};
				`REG_STATUS:      next_hrdata = {16'h0000, rotDir, baseEnable, homeValid, speed_reached_out,
					zero_speed_flag, speedMode, alarmActive, alarmCode};
				default:          next_hrdata = 32'h00000000;
			endcase
		end
	end

	wire [7:0] wrOffset = wrAddr - `REG_SPEED_FIRST;

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			hrdata     <= 32'h00000000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			wrPending  <= 1'b0;
			wrAddr     <= 8'h00;
			ctrlMode   <= `MODE_POSITION;
			selEnable  <= 1'b0;
			fwdPin     <= `RST_FWD_PIN;
			revPin     <= `RST_REV_PIN;
			accelTime  <= 16'h0000;
			decelTime  <= 16'h0000;
			torqueLim1 <= `RST_TORQUE_LIM;
			torqueLim2 <= `RST_TORQUE_LIM;
			zeroLevel  <= `RST_ZERO_LEVEL;
			saWindow   <= `RST_SA_WINDOW;
			for (i = 0; i < 7; i = i + 1)
				speedSet[i] <= 16'h0000;
		end
		else
		begin
			wrPending <= addrPhase && hwrite && (hsize == `HSIZE_WORD) && (haddr[31:8] == 24'h000000);
			wrAddr    <= rdAddr;
			if (addrPhase && !hwrite)
				hrdata <= next_hrdata;
			if (wrPending)
			begin
				if (wrAddr >= `REG_SPEED_FIRST && wrAddr <= `REG_SPEED_LAST)
					speedSet[wrOffset[4:2]] <= hwdata[15:0];
				case (wrAddr)
					`REG_CTRL:
					begin
						ctrlMode  <= hwdata[3:0];
						selEnable <= hwdata[4];
					end
					`REG_PIN_MAP:
					begin
						fwdPin <= hwdata[2:0];
						revPin <= hwdata[6:4];
					end
					`REG_ACCEL_TIME:  accelTime  <= hwdata[15:0];
					`REG_DECEL_TIME:  decelTime  <= hwdata[15:0];
					`REG_TORQUE_LIM1: torqueLim1 <= hwdata[15:0];
					`REG_TORQUE_LIM2: torqueLim2 <= hwdata[15:0];
					`REG_ZERO_LEVEL:  zeroLevel  <= hwdata[15:0];
					`REG_SA_WINDOW:   saWindow   <= hwdata[15:0];
					default:          ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Mode control, direction and torque limit
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			changeQ         <= 1'b0;
			changeBlocked   <= 1'b0;
			speedMode       <= 1'b0;
			droopClear      <= 1'b0;
			rotDir          <= `DIR_STOP;
			servoLock       <= 1'b0;
			torqueLimit     <= `RST_TORQUE_LIM;
			zero_speed_flag <= 1'b0;
		end
		else
		begin
			changeQ         <= sChange;
			zero_speed_flag <= zeroNow; // R20
			if (changeEdge)
				changeBlocked <= !zeroNow; // R09
			speedMode  <= next_speedMode;
			droopClear <= !speedMode && next_speedMode; // R08
			rotDir     <= next_dir;
			servoLock  <= next_baseEnable && (next_dir == `DIR_STOP); // R01
			if (sTorqueSel && (torqueLim2 < torqueLim1)) // R19
				torqueLimit <= torqueLim2;
			else
				torqueLimit <= torqueLim1;
		end
	end

	// ------------------------------------------------------------
	// Speed ramp and speed reached
	// ------------------------------------------------------------
	reg [7:0]  tickCnt;
	reg [15:0] rampCnt;
	wire       tick = (tickCnt == `TICK_LAST);

	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tickCnt           <= 8'h00;
			rampCnt           <= 16'h0000;
			speedCommand      <= 16'h0000;
			speed_reached_out <= 1'b0;
		end
		else
		begin
			tickCnt <= tick ? 8'h00 : tickCnt + 8'h01;
			if (!baseEnable)
			begin
				speedCommand <= 16'h0000;
				rampCnt      <= 16'h0000;
			end
			else if (speedCommand == target)
				rampCnt <= 16'h0000;
			else if (tick)
			begin
				if (rampCnt >= rampRate) // R03 R11
				begin
					rampCnt      <= 16'h0000;
					speedCommand <= upward ? speedCommand + 16'h0001 : speedCommand - 16'h0001;
				end
				else
					rampCnt <= rampCnt + 16'h0001;
			end
			speed_reached_out <= speedMode && baseEnable && (rotDir != `DIR_STOP) &&
				(speedDiff <= {1'b0, saWindow}); // R04
		end
	end

	// ------------------------------------------------------------
	// Alarm handling
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			resetQ      <= 1'b0;
			setQ        <= 1'b0;
			homeQ       <= 1'b0;
			pwrFailQ    <= 1'b0;
			pwrFailCnt  <= 17'h00000;
			alarmActive <= 1'b0;
			alarmCode   <= `ALM_NONE;
			baseEnable  <= 1'b0;
			homeValid   <= 1'b0;
		end
		else
		begin
			resetQ   <= sReset;
			setQ     <= sSet;
			homeQ    <= sHome;
			pwrFailQ <= ctrlPowerFail;
			if (!ctrlPowerFail)
				pwrFailCnt <= 17'h00000;
			else if (tick && pwrFailCnt < PWRFAIL_TICKS)
				pwrFailCnt <= pwrFailCnt + 17'h00001; // R15
			if (anyEvent && !alarmActive)
			begin
				alarmActive <= 1'b1;
				alarmCode   <= newCode; // R17
			end
			else if (alarmActive && clearReq && !anyCause && !anyEvent) // R13 R14
			begin
				alarmActive <= 1'b0;
				alarmCode   <= `ALM_NONE;
			end
			baseEnable <= next_baseEnable; // R12
			if (anyEvent && !speedMode)
				homeValid <= 1'b0; // R16
			else if (sHome && !homeQ)
				homeValid <= 1'b1;
		end
	end
endmodule // servo_speed_mode_control

// *** dv/ssmc_checker.sv ***
// Port-level assertions of the servo speed and mode control block
`timescale 1ns/10ps
`include "servo_speed_mode_control_defines.vh"
module ssmc_checker #(
	parameter [16:0] PWRFAIL_TICKS = 17'h00014
) (
	// Clock and reset
	input wire        clk_sys,
	input wire        resetn,
	// Bus answer
	input wire        hreadyout,
	input wire        hresp,
	// Fault levels
	input wire        overCurrent,
	input wire        overload1,
	input wire        overload2,
	input wire        regenError,
	// Drive outputs
	input wire        baseEnable,
	input wire [15:0] speedCommand,
	input wire [1:0]  rotDir,
	input wire        servoLock,
	input wire        droopClear,
	input wire        speedMode,
	input wire        speed_reached_out,
	input wire        zero_speed_flag,
	input wire        alarmActive,
	input wire [7:0]  alarmCode,
	input wire        homeValid
);
	wire anyFault = overCurrent | overload1 | overload2 | regenError;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
	a_fault_base_off: assert property (anyFault |=> !baseEnable) else $error("base on after fault");
	a_alarm_code: assert property (overCurrent && !alarmActive |=> alarmActive && alarmCode == `ALM_OVERCURRENT)
		else $error("overcurrent code wrong");
	a_clear_clean: assert property ($fell(alarmActive) |-> !$past(anyFault)) else $error("alarm cleared with fault");
	a_droop_on_rise: assert property ($rose(speedMode) |-> ##[0:1] droopClear) else $error("no droop clear");
	a_droop_pulse: assert property (droopClear |-> speedMode ##1 !droopClear) else $error("droop clear misplaced");
	a_mode_zero: assert property ($changed(speedMode) |-> zero_speed_flag || $past(zero_speed_flag))
		else $error("mode changed while moving");
	a_lock_dir: assert property (servoLock |-> baseEnable && rotDir == `DIR_STOP) else $error("lock without stop");
	a_reached_mode: assert property (speed_reached_out |-> speedMode || $past(speedMode))
		else $error("speed reached outside speed mode");
	a_home_lost: assert property ($rose(alarmActive) && !speedMode |-> ##[0:1] !homeValid)
		else $error("home kept after alarm");
	a_base_cmd_zero: assert property (!baseEnable && $past(!baseEnable) |-> speedCommand == 16'h0000)
		else $error("command with base off");
	a_ramp_step: assert property (baseEnable && $past(baseEnable)
		|-> speedCommand - $past(speedCommand) inside {16'h0000, 16'h0001, 16'hFFFF}) else $error("command stepped");
endmodule // ssmc_checker

// *** dv/motor_model.sv ***
// Motor and drive stage as seen by the control logic
`timescale 1ns/10ps
module motor_model (
	// Clock and reset
	input  wire         clk_sys,
	input  wire         resetn,
	// Drive side
	input  wire         baseEnable,
	input  wire  [15:0] speedCommand,
	output logic [15:0] actualSpeed
);
	logic [1:0]  div;
	logic [15:0] tgt;

	// Coasts down to standstill once the base is off
	assign tgt = baseEnable ? speedCommand : 16'h0000;
	always @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			div <= 2'h0;
			actualSpeed <= 16'h0000;
		end
		else
		begin
			div <= div + 2'h1;
			if (div == 2'h3 && $signed(tgt) > $signed(actualSpeed))
				actualSpeed <= actualSpeed + 16'h1;
			else if (div == 2'h3 && $signed(tgt) < $signed(actualSpeed))
				actualSpeed <= actualSpeed - 16'h1;
		end
	end
endmodule // motor_model

// *** dv/tb.sv ***
// Self-checking bench of the servo speed and mode control block
`timescale 1ns/10ps
`include "servo_speed_mode_control_defines.vh"
`define CHK(nm, ex, gt) \
	begin nChecks++; if ((gt) !== (ex)) begin miscompares++; \
	$display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module tb;
	localparam int TICK = 200;
	logic        clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, rotDir;
	logic [2:0]  hsize, speedSel;
	logic [5:0]  assignPins;
	logic        ctrl_change_in, alarm_reset_in, servo_on_in, torque_lim_sel_in, panelSetIn, homeDoneIn;
	logic        ctrlPowerFail, baseEnable, servoLock, droopClear, speedMode, speed_reached_out;
	logic        zero_speed_flag, alarmActive, homeValid;
	logic [3:0]  faults;
	logic [9:0]  busVoltage;
	logic [15:0] actualSpeed, speedCommand, torqueLimit;
	logic [7:0]  alarmCode;
	int          nChecks, miscompares, drops;

	servo_speed_mode_control #(.PWRFAIL_TICKS(17'h00014)) u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.assignPins(assignPins), .speed_sel0_in(speedSel[0]), .speed_sel1_in(speedSel[1]),
		.speed_sel2_in(speedSel[2]), .ctrl_change_in(ctrl_change_in), .alarm_reset_in(alarm_reset_in),
		.servo_on_in(servo_on_in), .torque_lim_sel_in(torque_lim_sel_in), .panelSetIn(panelSetIn),
		.homeDoneIn(homeDoneIn), .actualSpeed(actualSpeed), .busVoltage(busVoltage), .ctrlPowerFail(ctrlPowerFail),
		.overCurrent(faults[0]), .overload1(faults[1]), .overload2(faults[2]), .regenError(faults[3]),
		.baseEnable(baseEnable), .speedCommand(speedCommand), .rotDir(rotDir), .servoLock(servoLock),
		.droopClear(droopClear), .torqueLimit(torqueLimit), .speedMode(speedMode),
		.speed_reached_out(speed_reached_out), .zero_speed_flag(zero_speed_flag), .alarmActive(alarmActive),
		.alarmCode(alarmCode), .homeValid(homeValid));
	motor_model u_motor (.clk_sys(clk_sys), .resetn(resetn), .baseEnable(baseEnable),
		.speedCommand(speedCommand), .actualSpeed(actualSpeed));

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
		if (droopClear === 1'b1)
			drops++;

	task automatic print_verdict;
		if (miscompares == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bound(input int n, lim);
		if (n >= lim)
		begin
			miscompares++;
			print_verdict();
		end
	endtask
	// Single word transfer: address phase, then data phase, each held until hready
	task automatic bus(input logic w, input logic [31:0] a, d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= `HSIZE_WORD;
		@(posedge clk_sys);
		for (n = 0; n < 20 && hreadyout !== 1'b1; n++) @(posedge clk_sys);
		bound(n, 20);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		for (n = 0; n < 20 && hreadyout !== 1'b1; n++) @(posedge clk_sys);
		bound(n, 20);
		rd = hrdata;
	endtask
	task automatic rdchk(input string nm, input logic [31:0] a, ex);
		bus(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask
	task automatic wait_cmd(input logic [15:0] v);
		int n;
		for (n = 0; n < 4000 && speedCommand !== v; n++) @(posedge clk_sys);
		bound(n, 4000);
		`CHK("speedCommand", v, speedCommand)
	endtask
	task automatic clr(input logic panel);
		if (panel)
			panelSetIn <= 1'b1;
		else
			alarm_reset_in <= 1'b1;
		cyc(5);
		panelSetIn <= 1'b0;
		alarm_reset_in <= 1'b0;
		cyc(5);
	endtask

	task automatic t_regs;
		rdchk("lim1", `REG_TORQUE_LIM1, 32'h3E8);
		rdchk("zlevel", `REG_ZERO_LEVEL, 32'h32);
		rdchk("window", `REG_SA_WINDOW, 32'h32);
		rdchk("pinmap", `REG_PIN_MAP, 32'h10);
		rdchk("unmapped", 32'h100, 32'h0);
		bus(1'b1, `REG_STATUS, 32'hFFFF);
		rdchk("status", `REG_STATUS, 32'h400);
		bus(1'b1, `REG_ZERO_LEVEL, 32'h1);
		bus(1'b1, `REG_SA_WINDOW, 32'h1);
		bus(1'b1, `REG_ACCEL_TIME, 32'h0);
		bus(1'b1, `REG_DECEL_TIME, 32'h0);
		for (int k = 0; k < 7; k++)
			bus(1'b1, `REG_SPEED_FIRST + 4 * k, k + 4);
	endtask
	task automatic t_dir;
		logic [1:0] expd [4] = '{`DIR_STOP, `DIR_CCW, `DIR_CW, `DIR_STOP};
		for (int i = 0; i < 4; i++)
		begin
			assignPins <= {4'h0, i[1:0]};
			cyc(6);
			`CHK("rotDir", expd[i], rotDir)
			`CHK("servoLock", expd[i] == `DIR_STOP, servoLock)
		end
		bus(1'b1, `REG_PIN_MAP, 32'h53);
		assignPins <= 6'h08;
		cyc(6);
		`CHK("remapFwd", `DIR_CCW, rotDir)
		assignPins <= 6'h20;
		cyc(6);
		`CHK("remapRev", `DIR_CW, rotDir)
		assignPins <= 6'h00;
	endtask
	task automatic t_speed;
		bus(1'b1, `REG_CTRL, 32'h12);
		assignPins <= 6'h08;
		for (int c = 0; c < 8; c++)
		begin
			speedSel <= c[2:0];
			cyc(6);
			wait_cmd(c < 2 ? 16'h4 : c[15:0] + 16'h3);
			cyc(40);
			`CHK("reached", 1'b1, speed_reached_out)
		end
		speedSel <= 3'h1;
		cyc(300);
		`CHK("ramp", 1'b1, speedCommand > 16'h7 && speedCommand < 16'hA)
		wait_cmd(16'h4);
		assignPins <= 6'h00;
		wait_cmd(16'h0);
	endtask
	task automatic t_change;
		bus(1'b1, `REG_CTRL, 32'h1);
		cyc(10);
		drops = 0;
		`CHK("posMode", 1'b0, speedMode)
		ctrl_change_in <= 1'b1;
		cyc(6);
		`CHK("spdMode", 1'b1, speedMode)
		assignPins <= 6'h08;
		cyc(250);
		`CHK("chgRamp", 1'b1, speedCommand == 16'h1 || speedCommand == 16'h2)
		wait_cmd(16'h5);
		ctrl_change_in <= 1'b0;
		cyc(6);
		`CHK("moving", 1'b1, speedMode)
		`CHK("notZero", 1'b0, zero_speed_flag)
		assignPins <= 6'h00;
		wait_cmd(16'h0);
		cyc(40);
		`CHK("blocked", 1'b1, speedMode)
		`CHK("zeroFlag", 1'b1, zero_speed_flag)
		ctrl_change_in <= 1'b1;
		cyc(6);
		ctrl_change_in <= 1'b0;
		cyc(6);
		`CHK("unblocked", 1'b0, speedMode)
		`CHK("droop", 1, drops)
	endtask
	task automatic t_torque;
		bus(1'b1, `REG_TORQUE_LIM1, 32'h100);
		bus(1'b1, `REG_TORQUE_LIM2, 32'h80);
		cyc(6);
		`CHK("lim1", 16'h100, torqueLimit)
		torque_lim_sel_in <= 1'b1;
		cyc(6);
		`CHK("lim2", 16'h80, torqueLimit)
		bus(1'b1, `REG_TORQUE_LIM2, 32'h200);
		cyc(2);
		`CHK("limMin", 16'h100, torqueLimit)
	endtask
	task automatic t_alarm;
		logic [7:0] codes [5] = '{`ALM_OVERCURRENT, `ALM_OVERLOAD1, `ALM_OVERLOAD2, `ALM_REGEN, `ALM_UNDERVOLT};
		for (int i = 0; i < 5; i++)
		begin
			homeDoneIn <= 1'b1;
			cyc(5);
			homeDoneIn <= 1'b0;
			cyc(3);
			`CHK("homeSet", 1'b1, homeValid)
			if (i < 4)
				faults <= 4'h1 << i;
			else
				busVoltage <= `BUS_LOW_VOLTS;
			cyc(3);
			`CHK("alarmCode", codes[i], alarmCode)
			`CHK("baseOff", 1'b0, baseEnable)
			`CHK("homeLost", 1'b0, homeValid)
			clr(i[0]);
			`CHK("heldAlarm", 1'b1, alarmActive)
			faults <= 4'h0;
			busVoltage <= 10'h12C;
			cyc(2);
			clr(i[0]);
			`CHK("cleared", 1'b0, alarmActive)
		end
		ctrlPowerFail <= 1'b1;
		cyc(10 * TICK);
		ctrlPowerFail <= 1'b0;
		cyc(5);
		`CHK("shortFail", 1'b0, alarmActive)
		ctrlPowerFail <= 1'b1;
		cyc(21 * TICK);
		ctrlPowerFail <= 1'b0;
		cyc(5);
		`CHK("longFail", `ALM_UNDERVOLT, alarmCode)
		clr(1'b0);
		`CHK("failCleared", 1'b0, alarmActive)
	endtask
	// Alarm cleared by a power cycle, modelled by a mid-run reset
	task automatic t_power;
		faults <= 4'h1;
		cyc(3);
		`CHK("almSet", `ALM_OVERCURRENT, alarmCode)
		resetn <= 1'b0;
		faults <= 4'h0;
		cyc(3);
		resetn <= 1'b1;
		cyc(2);
		`CHK("powerClear", 1'b0, alarmActive)
		`CHK("codeClear", `ALM_NONE, alarmCode)
	endtask

	initial
	begin
		resetn = 1'b0;
		{hsel, hwrite, ctrl_change_in, alarm_reset_in, servo_on_in} = 5'h0;
		{torque_lim_sel_in, panelSetIn, homeDoneIn, ctrlPowerFail} = 4'h0;
		{haddr, hwdata, htrans, hsize, speedSel, assignPins, faults} = '0;
		busVoltage = 10'h12C;
		cyc(3);
		resetn <= 1'b1;
		cyc(2);
		t_regs();
		servo_on_in <= 1'b1;
		t_dir();
		t_speed();
		t_change();
		t_torque();
		t_alarm();
		t_power();
		print_verdict();
	end
endmodule // tb

bind servo_speed_mode_control ssmc_checker #(.PWRFAIL_TICKS(PWRFAIL_TICKS)) u_chk (
	.clk_sys(clk_sys), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp), .overCurrent(overCurrent),
	.overload1(overload1), .overload2(overload2), .regenError(regenError), .baseEnable(baseEnable),
	.speedCommand(speedCommand), .rotDir(rotDir), .servoLock(servoLock), .droopClear(droopClear),
	.speedMode(speedMode), .speed_reached_out(speed_reached_out), .zero_speed_flag(zero_speed_flag),
	.alarmActive(alarmActive), .alarmCode(alarmCode), .homeValid(homeValid));
